//--- bench/dbra_mcu_model.sv
`timescale 1ns/1ps
module dbra_mcu_model (
  input wire clock_i,
  input wire miso_i,
  input wire miso_oe_i,
  output reg sclk_o = 1'b0,
  output reg cs_n_o = 1'b1,
  output reg mosi_o = 1'b0
);
  reg last = 1'b0;
  // A released line shows the inverse of the last bit, so stale data never matches
  wire line = miso_oe_i ? miso_i : ~last;
  always @(posedge clock_i) begin
    if (miso_oe_i) begin
      last <= miso_i;
    end
  end
  task xfer(input [7:0] cmd, input [31:0] wd, output [31:0] rd);
    integer i;
    integer nb;
    begin
      nb = 8 * (cmd[6:5] + 1);
      rd = 32'h0;
      cs_n_o = 1'b0;
      for (i = 0; i < 8 + nb; i = i + 1) begin
        mosi_o = (i < 8) ? cmd[7 - i] : wd[nb + 7 - i];
        #62.5 sclk_o = 1'b1;
        if (i >= 8) begin
          rd = {rd[30:0], line};
        end
        #62.5 sclk_o = 1'b0;
      end
      #62.5 cs_n_o = 1'b1;
      #125;
    end
  endtask
endmodule

//--- bench/dbra_props.sv
`timescale 1ns/1ps
module dbra_props (
  input wire clock_i,
  input wire resetn_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire miso_o,
  input wire miso_oe_o,
  input wire soft_reset_o,
  input wire strobe_osc_enable_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  reset_out_a: assert property (disable iff (1'b0) !resetn_i |-> !miso_oe_o &&
    !soft_reset_o && !strobe_osc_enable_o) else $error("outputs set in reset");
  soe_write_a: assert property ($changed(strobe_osc_enable_o) |-> !cs_n_i)
    else $error("strobe changed idle");
  rst_write_a: assert property ($changed(soft_reset_o) |-> !cs_n_i)
    else $error("soft reset changed idle");
  read_nowrite_a: assert property (miso_oe_o |-> $stable(soft_reset_o) &&
    $stable(strobe_osc_enable_o)) else $error("write during read");
  miso_hold_a: assert property (sclk_i [*5] |-> $stable(miso_o))
    else $error("miso moved while sclk high");
  oe_edge_a: assert property ($rose(miso_oe_o) |-> !cs_n_i && !sclk_i)
    else $error("oe rose off a falling edge");
  idle_a: assert property (cs_n_i [*6] |-> !miso_oe_o && !miso_o)
    else $error("driving while idle");
  oe_drop_a: assert property ($rose(cs_n_i) |-> ##[1:6] !miso_oe_o)
    else $error("oe held after deselect");
endmodule

//--- bench/dbra_reg_access_tb_top.sv
`timescale 1ns/1ps
module dbra_reg_access_tb_top;
  reg clock_i = 1'b0;
  reg resetn_i = 1'b1;
  reg pll = 1'b0;
  reg lv = 1'b0;
  reg bank_a = 1'b1;
  wire sclk, cs_n, mosi, miso, oe, srst, strobe_osc_enable;
  integer fails = 0;
  integer n_compared = 0;
  always #4 clock_i = ~clock_i;
  dbra_reg_access DUT (.clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe),
    .pll_lock_status_i(pll), .low_voltage_event_i(lv), .signal_strength_result_i(8'h5a),
    .bank_a_active_i(bank_a), .soft_reset_o(srst), .strobe_osc_enable_o(strobe_osc_enable));
  dbra_mcu_model mcu (.clock_i(clock_i), .miso_i(miso), .miso_oe_i(oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi));
  task stop_test;
    begin
      if (fails == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock_i);
      #1;
    end
  endtask
  task chk(input [39:0] nm, input [31:0] ex, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== ex) begin
        fails = fails + 1;
        $display("[FAIL] %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task rw(input [7:0] cmd, input [31:0] wd, input [31:0] ex);
    reg [31:0] rd;
    begin
      tick(1);
      mcu.xfer(cmd, wd, rd);
      if (cmd[7])
        chk("rdata", ex, rd);
    end
  endtask
  initial begin
    resetn_i = 1'b0;
    tick(6);
    resetn_i = 1'b1;
    tick(4);
    rw(8'h7e, 32'ha53c_8101, 32'h0);
    chk("srst", 1'b1, srst);
    chk("soe", 1'b1, strobe_osc_enable);
    rw(8'hfe, 32'h0, 32'ha53c_8101);
    rw(8'h30, 32'h0000_8000, 32'h0);
    chk("soe", 1'b1, strobe_osc_enable);
    pll = 1'b1;
    lv = 1'b1;
    tick(4);
    lv = 1'b0;
    rw(8'hd0, 32'h0, 32'h0000_010d);
    pll = 1'b0;
    bank_a = 1'b0;
    lv = 1'b1;
    tick(4);
    lv = 1'b0;
    rw(8'h02, 32'h0000_00ff, 32'h0);
    rw(8'h82, 32'h0, 32'h0000_00f2);
    rw(8'h0c, 32'h0000_00ff, 32'h0);
    rw(8'h9c, 32'h0, 32'h0000_005a);
    stop_test;
  end
  initial begin
    #100000;
    fails = fails + 1;
    stop_test;
  end
endmodule
bind dbra_reg_access dbra_props u_props (.clock_i(clock_i), .resetn_i(resetn_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .soft_reset_o(soft_reset_o), .strobe_osc_enable_o(strobe_osc_enable_o));

//--- verilog/dbra_defs.vh
// Functional notes
// RULE1 - Decode a byte-wide register space of at most 32 locations.
// RULE2 - Controller puts start address in command byte; transfer begins there.
// RULE3 - Address counter advances after each byte until count field is exhausted.
// RULE4 - Same scan for reads and writes; writes to read-only bits change nothing.
// RULE5 - Past last implemented address the counter wraps to address zero.
// RULE6 - Every register of both banks is readable and writable at any time. The code gives the signal strength register no writable bit.
// RULE7 - Plain read-only bits return their value and ignore writes.
// RULE8 - Clear-on-access bits return their value, then any access clears them.
// RULE9 - Mirrored bank B bits return the bank A value.
// RULE10 - PLL lock bit is live lock state, same through both banks.
// RULE11 - Low-voltage flag latches detector events and reads same in both banks.
// RULE12 - Reading or writing the low-voltage flag register clears the flag.
// RULE13 - Strobe oscillator enable is written only via bank A; bank B mirrors it.
// RULE14 - Signal strength bits come straight from the converter in either bank.
// RULE15 - Bank indicator reads one for bank A active, zero for bank B.
// RULE16 - Software reset bit exists only in bank A first configuration register.
`ifndef DBRA_DEFS_VH
`define DBRA_DEFS_VH
`define DBRA_LAST_ADDR 5'h1f
`define DBRA_BANK_BIT 4
`define DBRA_CFG1 4'h0
`define DBRA_CFG2 4'h1
`define DBRA_CFG3 4'h2
`define DBRA_SSR 4'hc
`define DBRA_RESET_BIT 7
`define DBRA_SOE_BIT 0
`define DBRA_OLS_BIT 3
`define DBRA_LVD_BIT 2
`define DBRA_BANKS_BIT 0
`define DBRA_CFG3_RO_MASK 8'h0d
`define DBRA_REG_RESET 8'h00
`define DBRA_CMD_RD_BIT 7
`endif

//--- verilog/dbra_reg_access.v
`timescale 1ns/1ps
`include "dbra_defs.vh"
module dbra_reg_access #(
  parameter [4:0] LAST_ADDR = `DBRA_LAST_ADDR
) (
  input wire clock_i,
  input wire resetn_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  output wire miso_o,
  output reg miso_oe_o,
  input wire pll_lock_status_i,
  input wire low_voltage_event_i,
  input wire [7:0] signal_strength_result_i,
  input wire bank_a_active_i,
  output wire soft_reset_o,
  output wire strobe_osc_enable_o
);
  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  // Release is synchronised so every flop leaves reset in the same cycle
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Pins and analog status are asynchronous to clock_i
  reg [1:0] sclk_s, cs_s, mosi_s, lock_s, lvd_s;
  wire [7:0] ssr_s2;
  reg sclk_d;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      lock_s <= 2'h0;
      lvd_s <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], sclk_i};
      cs_s <= {cs_s[0], cs_n_i};
      mosi_s <= {mosi_s[0], mosi_i};
      lock_s <= {lock_s[0], pll_lock_status_i};
      lvd_s <= {lvd_s[0], low_voltage_event_i};
      sclk_d <= sclk_s[1];
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire sclk_fall = ~sclk_s[1] & sclk_d;
  // Deselect wins over any edge in the same cycle, so a cut byte is dropped
  wire cs_idle = cs_s[1];

  // One chain per bit; a word caught mid-conversion may mix old and new bits
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ssr_sync
      reg [1:0] sync;
      always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          sync <= 2'h0;
        end else begin
          sync <= {sync[0], signal_strength_result_i[g]};
        end
      end
      assign ssr_s2[g] = sync[1];
    end
  endgenerate

  reg [7:0] mem [0:31]; // see RULE1
  reg lvd_flag;
  reg [4:0] addr;
  reg [2:0] remain;
  reg [2:0] bitcnt;
  reg [7:0] rx;
  reg [7:0] tx;
  reg in_cmd;
  reg is_read;
  reg load_pend;
  integer i;

  assign miso_o = tx[7];
  assign soft_reset_o = mem[{1'b0, `DBRA_CFG1}][`DBRA_RESET_BIT];
  assign strobe_osc_enable_o = mem[{1'b0, `DBRA_CFG2}][`DBRA_SOE_BIT];

  function [4:0] next_addr_f;
    input [4:0] a;
    begin
      next_addr_f = (a == LAST_ADDR) ? 5'h00 : a + 5'h01; // see RULE5
    end
  endfunction

  // Bits that a serial write may change
  function [7:0] wmask_f;
    input [4:0] a;
    reg b;
    begin
      b = a[`DBRA_BANK_BIT];
      wmask_f = 8'hff;
      if (a[3:0] == `DBRA_SSR) begin // see RULE7, RULE14
        wmask_f = 8'h00;
      end
      if (a[3:0] == `DBRA_CFG3) begin // see RULE4, RULE7
        wmask_f = ~`DBRA_CFG3_RO_MASK;
      end
      if (b && a[3:0] == `DBRA_CFG2) begin // see RULE13
        wmask_f[`DBRA_SOE_BIT] = 1'b0;
      end
      if (b && a[3:0] == `DBRA_CFG1) begin // see RULE16
        wmask_f[`DBRA_RESET_BIT] = 1'b0;
      end
    end
  endfunction

  function [7:0] rdata_f;
    input [4:0] a;
    reg [7:0] v;
    begin
      v = mem[a]; // see RULE6
      case (a[3:0])
        `DBRA_CFG1: begin
          if (a[`DBRA_BANK_BIT]) begin // see RULE16
            v[`DBRA_RESET_BIT] = 1'b0;
          end
        end
        `DBRA_CFG2: begin
          v[`DBRA_SOE_BIT] = mem[{1'b0, `DBRA_CFG2}][`DBRA_SOE_BIT]; // see RULE9, RULE13
        end
        `DBRA_CFG3: begin
          v[`DBRA_OLS_BIT] = lock_s[1]; // see RULE10
          v[`DBRA_LVD_BIT] = lvd_flag; // see RULE8, RULE11
          v[`DBRA_BANKS_BIT] = bank_a_active_i; // see RULE15
        end
        `DBRA_SSR: begin
          v = ssr_s2; // see RULE14
        end
        default: begin
          v = mem[a];
        end
      endcase
      rdata_f = v;
    end
  endfunction

  wire [7:0] rx_next = {rx[6:0], mosi_s[1]};
  wire byte_done = sclk_rise && !cs_idle && bitcnt == 3'h7;
  // Bytes past the count are shifted in and dropped
  wire wr_data = byte_done && !in_cmd && !is_read && remain != 3'h0;
  wire rd_load = sclk_fall && !cs_idle && load_pend;
  wire acc_cfg3 = (wr_data || rd_load) && addr[3:0] == `DBRA_CFG3;

  // A detector event in the clearing cycle keeps the flag set
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lvd_flag <= 1'b0;
    end else begin
      lvd_flag <= lvd_s[1] | (lvd_flag & ~acc_cfg3); // see RULE11, RULE12, RULE8
    end
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 32; i = i + 1) begin
        mem[i] <= `DBRA_REG_RESET;
      end
      addr <= 5'h00;
      remain <= 3'h0;
      bitcnt <= 3'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      in_cmd <= 1'b1;
      is_read <= 1'b0;
      load_pend <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (cs_idle) begin
      bitcnt <= 3'h0;
      in_cmd <= 1'b1;
      is_read <= 1'b0;
      load_pend <= 1'b0;
      remain <= 3'h0;
      miso_oe_o <= 1'b0;
      tx <= 8'h00;
    end else begin
      if (sclk_rise) begin
        rx <= rx_next;
        bitcnt <= bitcnt + 3'h1;
      end
      if (byte_done && in_cmd) begin
        in_cmd <= 1'b0;
        is_read <= rx_next[`DBRA_CMD_RD_BIT];
        addr <= rx_next[4:0]; // see RULE2
        remain <= {1'b0, rx_next[6:5]} + 3'h1;
        load_pend <= rx_next[`DBRA_CMD_RD_BIT];
      end
      if (wr_data) begin
        mem[addr] <= (mem[addr] & ~wmask_f(addr)) | (rx_next & wmask_f(addr)); // see RULE4
        addr <= next_addr_f(addr); // see RULE3
        remain <= remain - 3'h1;
      end
      if (byte_done && !in_cmd && is_read && remain != 3'h0) begin
        load_pend <= 1'b1;
      end
      // Loading on the falling edge keeps the MSB stable for the next rising edge
      if (rd_load) begin
        tx <= rdata_f(addr);
        miso_oe_o <= 1'b1;
        addr <= next_addr_f(addr); // see RULE3, RULE4
        remain <= remain - 3'h1;
        load_pend <= 1'b0;
      end else if (sclk_fall && !in_cmd && is_read) begin
        tx <= {tx[6:0], 1'b0};
        // Release the line only once the last counted byte has gone out
        if (remain == 3'h0 && bitcnt == 3'h0) begin
          miso_oe_o <= 1'b0;
        end
      end
    end
  end
endmodule
